// >>> rtl/bmf_pkg.sv
// constants, types and register map of the buck mode and fault controller
// assumes a 250 MHz pclk and digitised comparator levels from the analog front end
package bmf_pkg;
    // clock and time base
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned US_FLOOR_NS = 40000;
    localparam int unsigned OVP_FILT_NS = 5000;
    localparam int unsigned US_FLOOR_CYC = (US_FLOOR_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned OVP_FILT_CYC = (OVP_FILT_NS * CLK_MHZ + 999) / 1000;
    // switching-cycle counts
    localparam int unsigned SKIP_ENTRY_CNT = 8;
    localparam int unsigned UV_TRIP_CNT = 8;
    // register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    // control fields and reset value
    localparam int unsigned CTRL_US_BIT = 0;
    localparam int unsigned CTRL_PS_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;
    // status field positions
    localparam int unsigned ST_OVP_BIT = 0;
    localparam int unsigned ST_UV_BIT = 1;
    localparam int unsigned ST_SS_BIT = 2;
    localparam int unsigned ST_PG_BIT = 3;
    localparam int unsigned ST_CL_BIT = 4;
    localparam int unsigned ST_SMART_BIT = 5;
    localparam int unsigned ST_SKIP_BIT = 6;
    localparam int unsigned ST_PHASE_LSB = 8;
    // switching phases
    typedef enum logic [2:0] {PH_OFF, PH_SKIP, PH_ON, PH_LOW, PH_OVP} bmf_phase_t;
    // whole controller state
    typedef struct packed {
        bmf_phase_t phase;
        logic hs;
        logic hs_fast;
        logic ls;
        logic tri_st;
        logic os_start;
        logic ss_act;
        logic ss_chg;
        logic pg_oe;
        logic pg_out;
        logic light_load_skip_mode_mode;
        logic smart;
        logic us_pull;
        logic zc_seen;
        logic curlim;
        logic [3:0] skip_cnt;
        logic [3:0] uv_cnt;
        logic [10:0] ovp_cnt;
        logic [15:0] us_cnt;
        logic ovp_lat;
        logic uv_lat;
        logic en_prev;
        logic [1:0] ctrl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } bmf_state_t;
endpackage : bmf_pkg

// >>> rtl/bmf_ctrl.sv
// mode sequencing and fault latches of the synchronous buck controller
// assumes comparator levels synchronous to pclk and an APB master on the register port
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module bmf_ctrl #(
    parameter int unsigned US_FLOOR_CYC = bmf_pkg::US_FLOOR_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // supply and enable levels
    input wire logic supply_lockout_ok,
    input wire logic enable_powersave_input_on,
    input wire logic enable_powersave_input_high,
    // feedback comparator levels
    input wire logic feedback_sense_below_ref,
    input wire logic feedback_sense_below_ss,
    input wire logic feedback_sense_above_smart,
    input wire logic feedback_sense_above_ovp,
    input wire logic feedback_sense_below_uv,
    input wire logic feedback_sense_below_pg,
    input wire logic feedback_sense_above_pg_rec,
    input wire logic soft_start_ramp_full,
    // power stage sense
    input wire logic on_time_done,
    input wire logic zero_cross,
    input wire logic switch_node_sense,
    input wire logic valley_limit_sense,
    // gate drive
    output logic high_side_gate_drive,
    output logic high_side_fast_drive,
    output logic low_side_gate_drive,
    output logic gate_tristate,
    output logic on_time_start,
    // soft-start and power good
    output logic soft_start_charge,
    output logic power_good_output_out,
    output logic power_good_output_oe
);
    // state register and its next value
    bmf_pkg::bmf_state_t s_q;
    bmf_pkg::bmf_state_t s_d;

    // decoded enable and mode terms
    logic en_on;
    logic light_load_skip_mode_en;
    logic us_mode;
    logic run;
    logic trigger;
    logic cycle_start;
    logic pg_bad;
    logic wr_acc;
    logic [1:0] addr_hit; // one-hot register select of the current address

    // address decode shared by read and write paths
    function automatic logic [1:0] dec_addr(input logic [7:0] a);
        dec_addr = {a == bmf_pkg::STATUS_OFS, a == bmf_pkg::CTRL_OFS};
    endfunction : dec_addr

    // status word assembly
    function automatic logic [31:0] status_word(input bmf_pkg::bmf_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[bmf_pkg::ST_OVP_BIT] = s.ovp_lat;
        w[bmf_pkg::ST_UV_BIT] = s.uv_lat;
        w[bmf_pkg::ST_SS_BIT] = s.ss_act;
        w[bmf_pkg::ST_PG_BIT] = ~s.pg_oe;
        w[bmf_pkg::ST_CL_BIT] = s.curlim;
        w[bmf_pkg::ST_SMART_BIT] = s.smart;
        w[bmf_pkg::ST_SKIP_BIT] = s.light_load_skip_mode_mode;
        w[bmf_pkg::ST_PHASE_LSB +: 3] = s.phase;
        status_word = w;
    endfunction : status_word

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.os_start = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        // enable low is off, floating is forced continuous, high allows skip
        en_on = enable_powersave_input_on;
        light_load_skip_mode_en = enable_powersave_input_on & enable_powersave_input_high & s_q.ctrl[bmf_pkg::CTRL_PS_BIT];
        us_mode = light_load_skip_mode_en & s_q.ctrl[bmf_pkg::CTRL_US_BIT];
        s_d.en_prev = en_on;

        // enable falling edge or supply loss clears the latches
        if ((s_q.en_prev & ~en_on) | ~supply_lockout_ok) begin
            s_d.ovp_lat = 1'b0;
            s_d.uv_lat = 1'b0;
            s_d.uv_cnt = 4'h0;
        end

        // overvoltage filter, armed from enable onward
        if (en_on & supply_lockout_ok & feedback_sense_above_ovp & ~s_q.ovp_lat) begin
            if (s_q.ovp_cnt == 11'(bmf_pkg::OVP_FILT_CYC - 1)) begin
                s_d.ovp_lat = 1'b1;
                s_d.ovp_cnt = 11'h000;
            end else begin
                s_d.ovp_cnt = s_q.ovp_cnt + 11'h001;
            end
        end else begin
            s_d.ovp_cnt = 11'h000;
        end

        // running only with supply, enable and no latched fault
        run = supply_lockout_ok & en_on & ~s_d.ovp_lat & ~s_d.uv_lat;

        // soft-start rearmed while stopped, done once the ramp is full
        if (!run) begin
            s_d.ss_act = 1'b1;
        end else if (soft_start_ramp_full) begin
            s_d.ss_act = 1'b0;
        end
        s_d.ss_chg = run;

        // on-time trigger: ramp fraction in soft-start, fixed reference after
        trigger = s_q.ss_act ? feedback_sense_below_ss : feedback_sense_below_ref;

        // valley limit only looked at while the low side conducts
        s_d.curlim = s_q.ls & valley_limit_sense;

        // new on-time only from low or skip phase, never under limit
        cycle_start = run & trigger & ~s_d.curlim & ((s_q.phase == bmf_pkg::PH_LOW) | (s_q.phase == bmf_pkg::PH_SKIP));

        // gap timer since the last high-side pulse
        if (cycle_start) begin
            s_d.us_cnt = 16'h0000;
        end else if (s_q.us_cnt != 16'hFFFF) begin
            s_d.us_cnt = s_q.us_cnt + 16'h0001;
        end

        // phase sequencing
        case (s_q.phase)
            // stopped: wait for the enables, both switches off
            bmf_pkg::PH_OFF: begin
                if (run) begin
                    s_d.phase = bmf_pkg::PH_SKIP;
                end
            end
            // high side on until the one-shot ends
            bmf_pkg::PH_ON: begin
                if (switch_node_sense) begin
                    s_d.hs_fast = 1'b1;
                end
                if (on_time_done) begin
                    s_d.phase = bmf_pkg::PH_LOW;
                    s_d.hs_fast = 1'b0;
                end
            end
            // low side on, watch for zero current
            bmf_pkg::PH_LOW: begin
                if (zero_cross) begin
                    s_d.zc_seen = 1'b1;
                    if (!s_q.us_pull && !s_q.smart && !s_d.curlim &&
                        (s_q.ss_act || s_q.light_load_skip_mode_mode || us_mode)) begin
                        s_d.phase = bmf_pkg::PH_SKIP;
                    end
                end
            end
            // both off until the trigger, or the gap floor runs out
            bmf_pkg::PH_SKIP: begin
                if (us_mode && !s_q.ss_act && (s_q.us_cnt >= 16'(US_FLOOR_CYC))) begin
                    s_d.phase = bmf_pkg::PH_LOW;
                    s_d.us_pull = 1'b1;
                end
            end
            // overvoltage hold: low side latched on
            bmf_pkg::PH_OVP: begin
                s_d.phase = bmf_pkg::PH_OVP;
            end
            default: begin
                s_d.phase = bmf_pkg::PH_OFF;
            end
        endcase

        // smart skip: feedback ten percent high pulls the output down
        if (run && light_load_skip_mode_en && feedback_sense_above_smart && (s_q.phase != bmf_pkg::PH_ON)) begin
            s_d.smart = 1'b1;
            s_d.light_load_skip_mode_mode = 1'b0;
            s_d.skip_cnt = 4'h0;
            s_d.phase = bmf_pkg::PH_LOW;
        end

        // start of a switching cycle
        if (cycle_start) begin
            s_d.phase = bmf_pkg::PH_ON;
            s_d.hs_fast = 1'b0;
            s_d.os_start = 1'b1;
            s_d.smart = 1'b0;
            s_d.us_pull = 1'b0;
            s_d.zc_seen = 1'b0;
            // zero-crossing cycles counted toward skip mode
            if (light_load_skip_mode_en && !us_mode && s_q.zc_seen && !s_q.ss_act) begin
                if (s_q.skip_cnt == 4'(bmf_pkg::SKIP_ENTRY_CNT - 1)) begin
                    s_d.light_load_skip_mode_mode = 1'b1;
                end else if (!s_q.light_load_skip_mode_mode) begin
                    s_d.skip_cnt = s_q.skip_cnt + 4'h1;
                end
            end else begin
                // a cycle without a crossing returns to forced continuous
                s_d.skip_cnt = 4'h0;
                s_d.light_load_skip_mode_mode = 1'b0;
            end
            // undervoltage counted over consecutive cycles
            if (feedback_sense_below_uv) begin
                if (s_q.uv_cnt == 4'(bmf_pkg::UV_TRIP_CNT - 1)) begin
                    s_d.uv_lat = 1'b1;
                    s_d.uv_cnt = 4'h0;
                end else begin
                    s_d.uv_cnt = s_q.uv_cnt + 4'h1;
                end
            end else begin
                s_d.uv_cnt = 4'h0;
            end
        end

        // faults and lockout override the sequence
        if (s_d.ovp_lat) begin
            s_d.phase = bmf_pkg::PH_OVP;
        end else if (!(supply_lockout_ok && en_on && !s_d.uv_lat)) begin
            s_d.phase = bmf_pkg::PH_OFF;
        end else if (s_q.phase == bmf_pkg::PH_OVP) begin
            s_d.phase = bmf_pkg::PH_OFF;
        end
        if (s_d.phase == bmf_pkg::PH_OFF || s_d.phase == bmf_pkg::PH_OVP) begin
            s_d.light_load_skip_mode_mode = 1'b0;
            s_d.skip_cnt = 4'h0;
            s_d.smart = 1'b0;
            s_d.us_pull = 1'b0;
            s_d.zc_seen = 1'b0;
            s_d.hs_fast = 1'b0;
            s_d.os_start = 1'b0;
        end

        // gate drives follow the phase
        s_d.hs = (s_d.phase == bmf_pkg::PH_ON);
        s_d.ls = (s_d.phase == bmf_pkg::PH_LOW) || (s_d.phase == bmf_pkg::PH_OVP);
        s_d.tri_st = (s_d.phase == bmf_pkg::PH_OFF);

        // power good with hysteresis and fault gating
        pg_bad = !run || s_d.ss_act || feedback_sense_above_ovp || feedback_sense_below_pg;
        if (pg_bad) begin
            s_d.pg_oe = 1'b1;
        end else if (feedback_sense_above_pg_rec) begin
            s_d.pg_oe = 1'b0;
        end
        s_d.pg_out = 1'b0;

        // apb: answer in the first access cycle, data captured at setup
        wr_acc = psel & penable & s_q.pready & pwrite;
        addr_hit = dec_addr(paddr);
        if (psel && !penable) begin
            s_d.pready = 1'b1;
            s_d.pslverr = ~|addr_hit;
            if (addr_hit[0]) begin
                s_d.prdata = {30'h0000_0000, s_q.ctrl};
            end else if (addr_hit[1]) begin
                s_d.prdata = status_word(s_q);
            end else begin
                s_d.prdata = 32'h0000_0000;
            end
        end
        if (wr_acc && addr_hit[0]) begin
            s_d.ctrl = pwdata[1:0];
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctrl <= bmf_pkg::CTRL_RST;
            s_q.ss_act <= 1'b1;
            s_q.pg_oe <= 1'b1;
            s_q.tri_st <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign high_side_gate_drive = s_q.hs;
    assign high_side_fast_drive = s_q.hs_fast;
    assign low_side_gate_drive = s_q.ls;
    assign gate_tristate = s_q.tri_st;
    assign on_time_start = s_q.os_start;
    assign soft_start_charge = s_q.ss_chg;
    assign power_good_output_out = s_q.pg_out;
    assign power_good_output_oe = s_q.pg_oe;

    // checks on the sequencing
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ovp_low_side_a: assert property (s_q.ovp_lat |-> s_q.ls && !s_q.hs)
        else $error("overvoltage latch without low side drive");
    ovp_filter_a: assert property ($rose(s_q.ovp_lat) |-> $past(s_q.ovp_cnt) == 11'(bmf_pkg::OVP_FILT_CYC - 1))
        else $error("overvoltage tripped before filter time");
    ovp_pg_low_a: assert property (s_q.ovp_lat |-> s_q.pg_oe)
        else $error("power good released during overvoltage");
    uv_gates_off_a: assert property (s_q.uv_lat |-> !s_q.hs && !s_q.ls && s_q.tri_st)
        else $error("undervoltage latch with a gate on");
    hs_slow_start_a: assert property ($rose(s_q.hs) |-> !s_q.hs_fast ##1 (!s_q.hs_fast || $past(switch_node_sense)))
        else $error("high side fast drive without switch node rise");
    limit_blocks_a: assert property ((s_q.ls && valley_limit_sense) |=> !s_q.hs)
        else $error("on-time started under valley limit");
    pg_drop_a: assert property (feedback_sense_below_pg |=> s_q.pg_oe)
        else $error("power good not pulled low on low feedback");
    skip_entry_a: assert property ($rose(s_q.light_load_skip_mode_mode) |-> $past(s_q.skip_cnt) == 4'(bmf_pkg::SKIP_ENTRY_CNT - 1))
        else $error("skip mode entered without eight crossings");
    hs_oneshot_a: assert property ($rose(s_q.hs) |-> s_q.os_start ##1 !s_q.os_start)
        else $error("high side rose without one-cycle one-shot start");
    us_floor_a: assert property ($rose(s_q.us_pull) |-> $past(s_q.us_cnt) >= 16'(US_FLOOR_CYC))
        else $error("ultrasonic pull-down before the gap floor");
    ss_gate_a: assert property (!supply_lockout_ok |=> !s_q.hs && s_q.ss_act)
        else $error("switching without supply");

    // main scenarios
    skip_mode_c: cover property ($rose(s_q.light_load_skip_mode_mode));
    ovp_trip_c: cover property ($rose(s_q.ovp_lat));
    uv_trip_c: cover property ($rose(s_q.uv_lat));
    us_pull_c: cover property ($rose(s_q.us_pull));
endmodule : bmf_ctrl

// >>> dv/bmf_stage_model.sv
// behavioural power stage: one-shot, switch node, zero-current and valley sense
// assumes gate levels from the controller and a free-running pclk
`timescale 1ns/1ps
module bmf_stage_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // gate levels and scenario knobs
    input wire logic hs,
    input wire logic ls,
    input wire logic zc_en,
    input wire logic lim_req,
    // comparator levels back to the controller
    output logic on_time_done,
    output logic zero_cross,
    output logic switch_node_sense,
    output logic valley_limit_sense
);
    logic [3:0] hs_cnt; // cycles the high side has been on
    logic [3:0] ls_cnt; // cycles the low side has been on
    // saturating on-time counters, cleared when the gate drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_cnt <= 4'h0;
            ls_cnt <= 4'h0;
        end else begin
            hs_cnt <= !hs ? 4'h0 : (hs_cnt == 4'hF ? hs_cnt : hs_cnt + 4'h1);
            ls_cnt <= !ls ? 4'h0 : (ls_cnt == 4'hF ? ls_cnt : ls_cnt + 4'h1);
        end
    end
    // switch node rises a cycle into the pulse, low again once released
    assign switch_node_sense = hs && hs_cnt >= 4'h1;
    // one-shot ends after six cycles of high side
    assign on_time_done = hs && hs_cnt >= 4'h6;
    // inductor current reaches zero three cycles into the low side
    assign zero_cross = ls && zc_en && ls_cnt >= 4'h3;
    // sense node goes negative only through the conducting low side
    assign valley_limit_sense = ls && lim_req;
endmodule : bmf_stage_model

// >>> dv/tb.sv
// self-checking bench for the buck mode and fault controller
// assumes bmf_ctrl on APB and the behavioural power stage beside it
`timescale 1ns/1ps
module tb;
    localparam int unsigned FLOOR = 40; // shortened ultrasonic floor
    // clock, reset and apb
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    // supply, enable and comparator levels
    logic sup_ok, en_on, en_hi, b_ref, b_ss, a_smart, a_ovp, b_uv, b_pg, a_rec, ramp_full;
    // power stage and outputs
    logic otd, zc, sns, vls, hs, hs_fast, ls, tri_st, ots, ss_chg, pg_out, pg_oe, zc_en, lim_req;
    int fail_count, compares;
    // controller under test
    bmf_ctrl #(.US_FLOOR_CYC(FLOOR)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_lockout_ok(sup_ok),
        .enable_powersave_input_on(en_on), .enable_powersave_input_high(en_hi),
        .feedback_sense_below_ref(b_ref), .feedback_sense_below_ss(b_ss),
        .feedback_sense_above_smart(a_smart), .feedback_sense_above_ovp(a_ovp),
        .feedback_sense_below_uv(b_uv), .feedback_sense_below_pg(b_pg),
        .feedback_sense_above_pg_rec(a_rec), .soft_start_ramp_full(ramp_full),
        .on_time_done(otd), .zero_cross(zc), .switch_node_sense(sns), .valley_limit_sense(vls),
        .high_side_gate_drive(hs), .high_side_fast_drive(hs_fast), .low_side_gate_drive(ls),
        .gate_tristate(tri_st), .on_time_start(ots), .soft_start_charge(ss_chg),
        .power_good_output_out(pg_out), .power_good_output_oe(pg_oe));
    // far-side power stage
    bmf_stage_model stage (.pclk(pclk), .presetn(presetn), .hs(hs), .ls(ls), .zc_en(zc_en),
        .lim_req(lim_req), .on_time_done(otd), .zero_cross(zc), .switch_node_sense(sns),
        .valley_limit_sense(vls));
    // compare and count
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // apb transfer: setup, then access held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", pready, 1);
    endtask : apb
    // bounded wait for a level, then compare
    task automatic wait_on(ref logic s, input logic v, input int lim, input string nm);
        int n = 0;
        while (s !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk(nm, s, v);
    endtask : wait_on
    // one switching cycle: trigger, on-time, then low side
    task fire();
        b_ref <= 1'b1;
        b_ss <= 1'b1;
        wait_on(hs, 1'b1, 50, "fire_hs");
        b_ref <= 1'b0;
        b_ss <= 1'b0;
        wait_on(ls, 1'b1, 20, "fire_ls");
        // let the inductor current reach zero before the next trigger
        cyc(4);
    endtask : fire
    task rd_status();
        apb(1'b0, bmf_pkg::STATUS_OFS, 32'h0);
    endtask : rd_status
    // verdict and end of run
    task wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // watchdog
    initial begin
        cyc(40000);
        fail_count++;
        wrap_up();
    end
    initial begin
        {psel, penable, pwrite, sup_ok, en_on, en_hi, b_ref, b_ss, a_smart, a_ovp} = '0;
        {b_uv, b_pg, a_rec, ramp_full, zc_en, lim_req, presetn} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fail_count = 0;
        compares = 0;
        void'($urandom(20));
        cyc(8);
        chk("rst_tri", tri_st, 1);
        chk("rst_pg", pg_oe, 1);
        chk("pg_od", pg_out, 0);
        cyc(8);
        presetn <= 1'b1;
        // register map, random write data, unmapped and read-only places
        apb(1'b0, bmf_pkg::CTRL_OFS, 32'h0);
        chk("ctrl_rst", rd, {30'h0, bmf_pkg::CTRL_RST});
        d = $urandom;
        apb(1'b1, bmf_pkg::CTRL_OFS, d);
        apb(1'b0, bmf_pkg::CTRL_OFS, 32'h0);
        chk("ctrl_rw", rd, d & 32'h3);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped_err", err, 1);
        chk("unmapped_rd", rd, 0);
        apb(1'b1, bmf_pkg::STATUS_OFS, 32'hFFFFFFFF);
        rd_status();
        chk("status_ro", rd & 32'h3, 0);
        apb(1'b1, bmf_pkg::CTRL_OFS, 32'h0);
        // soft-start waits for enable, tracks the ramp, then power good
        sup_ok <= 1'b1;
        cyc(10);
        chk("ss_wait_en", ss_chg, 0);
        en_on <= 1'b1;
        b_ss <= 1'b1;
        wait_on(ss_chg, 1'b1, 20, "ss_run");
        wait_on(ots, 1'b1, 50, "ss_pulse");
        chk("pg_ramp", pg_oe, 1);
        b_ss <= 1'b0;
        a_rec <= 1'b1;
        ramp_full <= 1'b1;
        wait_on(pg_oe, 1'b0, 200, "pg_up");
        // exact pulse timing in forced continuous operation
        cyc(5);
        b_ref <= 1'b1;
        cyc(2);
        chk("hs_start", hs, 1);
        chk("ots", ots, 1);
        chk("hs_slow", hs_fast, 0);
        b_ref <= 1'b0;
        cyc(1);
        chk("ots_once", ots, 0);
        wait_on(hs_fast, 1'b1, 5, "hs_fast");
        wait_on(ls, 1'b1, 10, "ls_after");
        chk("hs_off", hs, 0);
        repeat ($urandom_range(6, 3)) begin
            cyc($urandom_range(8, 1));
            fire();
        end
        // valley limit holds the low side and blocks the trigger
        lim_req <= 1'b1;
        b_ref <= 1'b1;
        cyc(6);
        chk("lim_block", hs, 0);
        chk("lim_hold", ls, 1);
        lim_req <= 1'b0;
        wait_on(hs, 1'b1, 10, "lim_free");
        b_ref <= 1'b0;
        // power-good hysteresis
        b_pg <= 1'b1;
        a_rec <= 1'b0;
        wait_on(pg_oe, 1'b1, 10, "pg_low");
        b_pg <= 1'b0;
        cyc(6);
        chk("pg_hyst", pg_oe, 1);
        a_rec <= 1'b1;
        wait_on(pg_oe, 1'b0, 10, "pg_back");
        // counted skip mode: entry, zero-crossing turn-off, smart pull, exit
        en_hi <= 1'b1;
        zc_en <= 1'b1;
        apb(1'b1, bmf_pkg::CTRL_OFS, 32'h2);
        repeat (6) fire();
        rd_status();
        chk("skip_wait", rd[bmf_pkg::ST_SKIP_BIT], 0);
        repeat (2) fire();
        rd_status();
        chk("skip_in", rd[bmf_pkg::ST_SKIP_BIT], 1);
        fire();
        wait_on(ls, 1'b0, 10, "zc_off");
        cyc(10);
        chk("both_off", hs | ls, 0);
        a_smart <= 1'b1;
        wait_on(ls, 1'b1, 10, "smart_pull");
        rd_status();
        chk("smart_st", rd[bmf_pkg::ST_SMART_BIT], 1);
        a_smart <= 1'b0;
        fire();
        zc_en <= 1'b0;
        repeat (2) fire();
        rd_status();
        chk("skip_out", rd[bmf_pkg::ST_SKIP_BIT], 0);
        // ultrasonic variant: zero-current turn-off and the floor timer
        apb(1'b1, bmf_pkg::CTRL_OFS, 32'h3);
        zc_en <= 1'b1;
        fire();
        wait_on(ls, 1'b0, 10, "us_zc");
        cyc(15);
        chk("us_early", ls, 0);
        wait_on(ls, 1'b1, 30, "us_pull");
        zc_en <= 1'b0;
        // overvoltage filter restart, latch, and clear by enable
        a_ovp <= 1'b1;
        cyc(1200);
        a_ovp <= 1'b0;
        cyc(1);
        a_ovp <= 1'b1;
        cyc(1200);
        rd_status();
        chk("ovp_filter", rd[bmf_pkg::ST_OVP_BIT], 0);
        cyc(100);
        rd_status();
        chk("ovp_lat", rd[bmf_pkg::ST_OVP_BIT], 1);
        a_ovp <= 1'b0;
        b_ref <= 1'b1;
        cyc(10);
        chk("ovp_stop", hs, 0);
        chk("ovp_ls", ls, 1);
        chk("ovp_pg", pg_oe, 1);
        b_ref <= 1'b0;
        en_on <= 1'b0;
        cyc(5);
        chk("dis_pg", pg_oe, 1);
        rd_status();
        chk("ovp_clr", rd[bmf_pkg::ST_OVP_BIT], 0);
        // undervoltage over eight on-time starts, cleared by supply loss
        apb(1'b1, bmf_pkg::CTRL_OFS, 32'h0);
        en_hi <= 1'b0;
        en_on <= 1'b1;
        b_uv <= 1'b1;
        repeat (7) fire();
        chk("uv_wait", tri_st, 0);
        b_ref <= 1'b1;
        wait_on(tri_st, 1'b1, 50, "uv_latch");
        b_ref <= 1'b0;
        cyc(3);
        chk("uv_gates", hs | ls, 0);
        b_uv <= 1'b0;
        sup_ok <= 1'b0;
        cyc(3);
        rd_status();
        chk("uv_clr", rd[bmf_pkg::ST_UV_BIT], 0);
        wrap_up();
    end
endmodule : tb
